/* File: tsr_map.svh */
// register offsets, reset values, field positions and timing counts
`ifndef TSR_MAP_SVH
`define TSR_MAP_SVH
// ----------------------------------------
// byte addresses
// ----------------------------------------
`define TSR_A_HOLD 8'h13
`define TSR_A_SCTL 8'h14
`define TSR_A_SOPT 8'h15
`define TSR_A_GRP 8'h16
`define TSR_A_THR 8'h26
`define TSR_A_BL 8'h36
`define TSR_A_XOUT 8'h46
`define TSR_A_DOUT 8'h47
// ----------------------------------------
// reset values
// ----------------------------------------
`define TSR_R_HOLD 8'h19
`define TSR_R_SCTL 8'h05
`define TSR_R_SOPT 8'h04
`define TSR_R_GRP 2'h0
`define TSR_R_THR 8'h0A
`define TSR_R_BL 8'h04
`define TSR_R_XOUT 8'h00
`define TSR_R_DOUT 3'h0
// ----------------------------------------
// fields
// ----------------------------------------
`define TSR_F_SLIDER_HYSTERESIS 7:4
`define TSR_F_NKEY 3:0
`define TSR_F_RES 2:0
`define TSR_F_GRP 1:0
`define TSR_F_DOUT 4:2
`define TSR_RES_MAX 3'h6
`define TSR_REL_GAP 2
// ----------------------------------------
// timing
// ----------------------------------------
`define TSR_CLK_NS 100
`define TSR_TICK_MS 160
`define TSR_LP_MS 16
`define TSR_TICK_CYC (`TSR_TICK_MS * 1000000 / `TSR_CLK_NS)
`define TSR_LP_CYC (`TSR_LP_MS * 1000000 / `TSR_CLK_NS)
`endif

/* File: tsr_pkg.sv */
// types shared by the touch setup register block
package tsr_pkg;
  typedef enum logic [2:0] {ST_SLEEP, ST_START, ST_HI, ST_LO, ST_EVAL} tsr_st_t;
  typedef enum logic [1:0] {DIR_NONE, DIR_UP, DIR_DN} tsr_dir_t;
  typedef struct packed {
    tsr_st_t st;
    logic [7:0] hold;
    logic [7:0] sctl;
    logic [7:0] sopt;
    logic [15:0][1:0] grp;
    logic [15:0][7:0] thr;
    logic [15:0][7:0] bl;
    logic [7:0] xo;
    logic [2:0] go;
    logic [15:0][15:0] ref_v;
    logic [15:0] cal;
    logic [15:0] det;
    logic [3:0] key;
    logic [9:0] pcnt;
    logic [17:0] lsub;
    logic [7:0] lunits;
    logic [20:0] tsub;
    logic [7:0] ipos;
    logic [7:0] spos;
    tsr_dir_t dir;
    logic on;
    logic [7:0] x;
    logic [1:0] y;
    logic [2:0] gd;
    logic [2:0] goe;
    logic [7:0] rdata;
  } tsr_core_t;
  typedef struct packed {
    logic [7:0] cnt;
  } tsr_cd_t;
endpackage : tsr_pkg

/* File: tsr_countdown.sv */
// reloadable countdown in 0.16 s ticks, busy while nonzero
`timescale 1ns/1ps
module tsr_countdown (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic load,
  input wire logic [7:0] load_val,
  input wire logic tick,
  output logic busy
);
  import tsr_pkg::*;
  tsr_cd_t s_q, s_d;

  // load beats a tick in the same cycle so a fresh event gets the full interval
  always_comb begin
    s_d = s_q;
    if (load) begin
      s_d.cnt = load_val;
    end else if (tick && s_q.cnt != 8'h00) begin
      s_d.cnt = s_q.cnt - 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = s_q.cnt != 8'h00;
endmodule : tsr_countdown

/* File: tsr_core.sv */
// touch setup registers with scan sequencer, detection, slider and output drive
`timescale 1ns/1ps
`include "tsr_map.svh"
module tsr_core #(
  parameter int TICK_CYC = `TSR_TICK_CYC,
  parameter int LP_CYC = `TSR_LP_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] sleep_interval_setting,
  input wire logic [2:0] ded_dir,
  input wire logic [7:0] pwm_shared_en,
  input wire logic [2:0] pwm_ded_en,
  input wire logic pwm_level,
  input wire logic [15:0] key_signal,
  input wire logic [7:0] slider_raw_pos,
  output logic [7:0] drive_line,
  output logic [1:0] recv_en,
  output logic [2:0] ded_out,
  output logic [2:0] ded_oe,
  output logic [3:0] meas_key,
  output logic [15:0] key_detect,
  output logic [7:0] slider_pos,
  output logic slider_touch
);
  import tsr_pkg::*;

  tsr_core_t s_q, s_d;
  logic tick;
  logic hold_busy;
  logic awake_busy;
  logic hold_load;
  logic awake_load;
  logic adv;
  logic fin;
  logic blk;
  logic clash;
  logic [7:0] sl_mask;
  logic [7:0] tgt;
  logic [4:0] hys;
  logic [2:0] res;
  logic [3:0] k;
  logic [9:0] bl_x4;
  logic signed [17:0] dlt;
  logic signed [17:0] thr_s;
  // ----------------------------------------
  // register read mux
  // ----------------------------------------
  function automatic logic [7:0] rd_byte(input tsr_core_t s, input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == `TSR_A_HOLD) begin
      v = s.hold;
    end else if (a == `TSR_A_SCTL) begin
      v = s.sctl;
    end else if (a == `TSR_A_SOPT) begin
      v = s.sopt;
    end else if (a >= `TSR_A_GRP && a < `TSR_A_THR) begin
      v = {6'h00, s.grp[4'(a - `TSR_A_GRP)]};
    end else if (a >= `TSR_A_THR && a < `TSR_A_BL) begin
      v = s.thr[4'(a - `TSR_A_THR)];
    end else if (a >= `TSR_A_BL && a < `TSR_A_XOUT) begin
      v = s.bl[4'(a - `TSR_A_BL)];
    end else if (a == `TSR_A_XOUT) begin
      v = s.xo;
    end else if (a == `TSR_A_DOUT) begin
      v = {3'h0, s.go, 2'h0};
    end
    return v;
  endfunction : rd_byte
  // ----------------------------------------
  // interval timers
  // ----------------------------------------
  assign tick = s_q.tsub == 21'(TICK_CYC - 1);
  assign hold_load = |s_d.det;
  assign awake_load = s_d.det != s_q.det;

  // a written value of 0 would end the hold at once; the host avoids it
  tsr_countdown u_hold (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .load(hold_load),
    .load_val(s_q.hold),
    .tick(tick),
    .busy(hold_busy)
  );

  tsr_countdown u_awake (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .load(awake_load),
    .load_val(s_q.hold),
    .tick(tick),
    .busy(awake_busy)
  );
  // ----------------------------------------
  // per-key helpers
  // ----------------------------------------
  assign k = s_q.key;
  assign bl_x4 = {s_q.bl[k], 2'b00};
  assign dlt = $signed({2'b00, s_q.ref_v[k]}) - $signed({2'b00, key_signal});
  assign thr_s = $signed({10'h000, s_q.thr[k]});
  assign hys = {1'b0, s_q.sctl[`TSR_F_SLIDER_HYSTERESIS]} + 5'h01;
  assign res = (s_q.sopt[`TSR_F_RES] > `TSR_RES_MAX) ? `TSR_RES_MAX : s_q.sopt[`TSR_F_RES];

  always_comb begin
    sl_mask = 8'h00;
    blk = 1'b0;
    clash = 1'b0;
    for (int j = 0; j < 8; j++) begin
      sl_mask[j] = 4'(j) < s_q.sctl[`TSR_F_NKEY];
    end
    for (int j = 0; j < 16; j++) begin
      if (4'(j) != k && s_q.det[j] && s_q.grp[k] != 2'h0 && s_q.grp[j] == s_q.grp[k]
          && !(!k[3] && sl_mask[k[2:0]] && j < 8 && sl_mask[3'(j)])) begin
        blk = 1'b1;
      end
      for (int i = 0; i < j; i++) begin
        if (s_q.det[i] && s_q.det[j] && s_q.grp[i] != 2'h0 && s_q.grp[i] == s_q.grp[j]
            && !(j < 8 && sl_mask[3'(i)] && sl_mask[3'(j)])) begin
          clash = 1'b1;
        end
      end
    end
  end
  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    adv = 1'b0;
    fin = 1'b0;
    tgt = awake_busy ? 8'h01 : sleep_interval_setting;
    s_d.tsub = tick ? 21'h000000 : s_q.tsub + 21'h000001;
    // register port; scan reads settings live, so a write lands at the next key visit
    if (reg_wr) begin
      if (reg_addr == `TSR_A_HOLD) begin
        s_d.hold = reg_wdata;
      end else if (reg_addr == `TSR_A_SCTL) begin
        s_d.sctl = reg_wdata;
      end else if (reg_addr == `TSR_A_SOPT) begin
        s_d.sopt = {5'h00, reg_wdata[`TSR_F_RES]};
      end else if (reg_addr >= `TSR_A_GRP && reg_addr < `TSR_A_THR) begin
        s_d.grp[4'(reg_addr - `TSR_A_GRP)] = reg_wdata[`TSR_F_GRP];
      end else if (reg_addr >= `TSR_A_THR && reg_addr < `TSR_A_BL) begin
        s_d.thr[4'(reg_addr - `TSR_A_THR)] = reg_wdata;
      end else if (reg_addr >= `TSR_A_BL && reg_addr < `TSR_A_XOUT) begin
        s_d.bl[4'(reg_addr - `TSR_A_BL)] = reg_wdata;
      end else if (reg_addr == `TSR_A_XOUT) begin
        s_d.xo = reg_wdata;
      end else if (reg_addr == `TSR_A_DOUT) begin
        s_d.go = reg_wdata[`TSR_F_DOUT];
      end
    end
    if (reg_rd) begin
      s_d.rdata = rd_byte(s_q, reg_addr);
    end
    unique case (s_q.st)
      ST_SLEEP: begin
        if (tgt == 8'h00) begin
          s_d.lsub = '0;
          s_d.lunits = '0;
        end else if (s_q.lsub == 18'(LP_CYC - 1)) begin
          s_d.lsub = '0;
          if (s_q.lunits + 8'h01 >= tgt) begin
            s_d.lunits = '0;
            s_d.key = '0;
            s_d.st = ST_START;
          end else begin
            s_d.lunits = s_q.lunits + 8'h01;
          end
        end else begin
          s_d.lsub = s_q.lsub + 18'h00001;
        end
      end
      ST_START: begin
        if (s_q.bl[k] == 8'h00) begin
          s_d.det[k] = 1'b0;
          adv = 1'b1;
        end else begin
          s_d.pcnt = bl_x4;
          s_d.st = ST_HI;
        end
      end
      ST_HI: begin
        s_d.st = ST_LO;
      end
      ST_LO: begin
        s_d.pcnt = s_q.pcnt - 10'h001;
        s_d.st = (s_q.pcnt == 10'h001) ? ST_EVAL : ST_HI;
      end
      ST_EVAL: begin
        adv = 1'b1;
        if (!s_q.cal[k]) begin
          s_d.ref_v[k] = key_signal;
          s_d.cal[k] = 1'b1;
        end else begin
          if (!s_q.det[k]) begin
            if (dlt >= thr_s && !blk) begin
              s_d.det[k] = 1'b1;
            end
          end else if (dlt + $signed(18'(`TSR_REL_GAP)) < thr_s) begin
            s_d.det[k] = 1'b0;
          end
          // reference follows signal only with no detection and no hold
          if (!s_d.det[k] && !hold_busy) begin
            if (key_signal > s_q.ref_v[k]) begin
              s_d.ref_v[k] = s_q.ref_v[k] + 16'h0001;
            end else if (key_signal < s_q.ref_v[k]) begin
              s_d.ref_v[k] = s_q.ref_v[k] - 16'h0001;
            end
          end
        end
      end
      default: begin
        s_d.st = ST_SLEEP;
      end
    endcase
    if (adv) begin
      if (k == 4'hF) begin
        fin = 1'b1;
        s_d.st = ST_SLEEP;
      end else begin
        s_d.key = k + 4'h1;
        s_d.st = ST_START;
      end
    end
    // slider, hysteresis on the 8-bit position then scaled down
    if (fin) begin
      if (!(|(s_d.det[7:0] & sl_mask))) begin
        s_d.on = 1'b0;
        s_d.dir = DIR_NONE;
      end else if (!s_q.on) begin
        s_d.on = 1'b1;
        s_d.ipos = slider_raw_pos;
        s_d.dir = DIR_NONE;
      end else if (slider_raw_pos > s_q.ipos) begin
        if (s_q.dir == DIR_UP || slider_raw_pos - s_q.ipos >= {3'h0, hys}) begin
          s_d.ipos = slider_raw_pos;
          s_d.dir = DIR_UP;
        end
      end else if (slider_raw_pos < s_q.ipos) begin
        if (s_q.dir == DIR_DN || s_q.ipos - slider_raw_pos >= {3'h0, hys}) begin
          s_d.ipos = slider_raw_pos;
          s_d.dir = DIR_DN;
        end
      end
      s_d.spos = s_d.ipos >> res;
    end
    // pins
    if (s_d.st == ST_HI) begin
      s_d.x = 8'h01 << s_d.key[2:0];
    end else if (s_d.st == ST_SLEEP) begin
      s_d.x = (s_q.xo & ~pwm_shared_en) | (pwm_shared_en & {8{pwm_level}});
    end else begin
      s_d.x = 8'h00;
    end
    s_d.y = (s_d.st == ST_HI || s_d.st == ST_LO) ? 2'b01 << s_d.key[3] : 2'b00;
    s_d.gd = ((s_q.go & ~pwm_ded_en) | (pwm_ded_en & {3{pwm_level}})) & ded_dir;
    s_d.goe = ded_dir;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.st <= ST_SLEEP;
      s_q.dir <= DIR_NONE;
      s_q.hold <= `TSR_R_HOLD;
      s_q.sctl <= `TSR_R_SCTL;
      s_q.sopt <= `TSR_R_SOPT;
      s_q.grp <= {16{`TSR_R_GRP}};
      s_q.thr <= {16{`TSR_R_THR}};
      s_q.bl <= {16{`TSR_R_BL}};
      s_q.xo <= `TSR_R_XOUT;
      s_q.go <= `TSR_R_DOUT;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign drive_line = s_q.x;
  assign recv_en = s_q.y;
  assign ded_out = s_q.gd;
  assign ded_oe = s_q.goe;
  assign meas_key = s_q.key;
  assign key_detect = s_q.det;
  assign slider_pos = s_q.spos;
  assign slider_touch = s_q.on;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  sequence s_pulse;
    (s_q.x == (8'h01 << s_q.key[2:0]) && s_q.y == (2'b01 << s_q.key[3])) ##1 (s_q.x == 8'h00 && s_q.y != 2'b00);
  endsequence
  property p_drift_hold;
    s_q.st == ST_EVAL && hold_busy && s_q.cal[k] |=> s_q.ref_v == $past(s_q.ref_v);
  endproperty
  a_drift_hold: assert property (p_drift_hold) else $error("reference moved during hold");
  property p_awake;
    awake_load && s_q.hold > 8'h01 |=> awake_busy [*2];
  endproperty
  a_awake: assert property (p_awake) else $error("awake interval not restarted");
  property p_res;
    $past(fin) && $stable(s_q.sopt) && s_q.sopt[2:0] <= 3'h6
      |-> ({8'h00, s_q.spos} >> (4'h8 - {1'b0, s_q.sopt[2:0]})) == 16'h0000;
  endproperty
  a_res: assert property (p_res) else $error("slider position out of range");
  property p_pcnt;
    s_q.st == ST_START && s_q.bl[k] != 8'h00 |=> s_q.st == ST_HI && s_q.pcnt == $past(bl_x4);
  endproperty
  a_pcnt: assert property (p_pcnt) else $error("pulse count not four times length");
  property p_skip;
    s_q.st == ST_START && s_q.bl[k] == 8'h00 |=> s_q.st != ST_HI && s_q.y == 2'b00;
  endproperty
  a_skip: assert property (p_skip) else $error("disabled key was pulsed");
  property p_pulse;
    s_q.st == ST_HI |-> s_pulse;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse shape wrong");
  property p_quiet;
    s_q.st inside {ST_START, ST_LO, ST_EVAL} |-> s_q.x == 8'h00;
  endproperty
  a_quiet: assert property (p_quiet) else $error("static level during measurement");
  property p_group;
    !clash;
  endproperty
  a_group: assert property (p_group) else $error("two keys of one group detected");
endmodule : tsr_core

/* File: tsr_matrix_model.sv */
// sensing matrix model: key signals and charge-transfer pulse counts per key visit
`timescale 1ns/1ps
module tsr_matrix_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [3:0] meas_key,
  input wire logic [7:0] drive_line,
  input wire logic [1:0] recv_en,
  input wire logic [15:0] touch,
  input wire logic [7:0] depth,
  output logic [15:0] key_signal,
  output logic [15:0][9:0] key_pulses
);
  localparam logic [15:0] BASE = 16'h1000;
  logic [9:0] cnt_q;
  logic [3:0] key_q;
  logic drv_q;
  logic drv;
  // a finger absorbs charge, so the signal falls below the untouched level
  assign key_signal = touch[meas_key] ? BASE - {8'h00, depth} : BASE;
  // only a strobe with the matching receive line open moves charge
  assign drv = drive_line[meas_key[2:0]] & recv_en[meas_key[3]];
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
      key_q <= '0;
      drv_q <= 1'b0;
      key_pulses <= '0;
    end else begin
      drv_q <= drv;
      key_q <= meas_key;
      if (meas_key != key_q) begin
        key_pulses[key_q] <= cnt_q;
        cnt_q <= '0;
      end else if (drv && !drv_q) begin
        cnt_q <= cnt_q + 10'h001;
      end
    end
  end
endmodule : tsr_matrix_model

/* File: tb_top.sv */
// testbench for the touch setup register block
`timescale 1ns/1ps
`include "tsr_map.svh"
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] sleep_interval_setting = 8'h01;
  logic [2:0] ded_dir = 3'h0;
  logic [7:0] pwm_shared_en = 8'h00;
  logic [2:0] pwm_ded_en = 3'h0;
  logic pwm_level = 1'b0;
  logic [15:0] key_signal;
  logic [7:0] slider_raw_pos = 8'hB7;
  logic [7:0] drive_line;
  logic [1:0] recv_en;
  logic [2:0] ded_out;
  logic [2:0] ded_oe;
  logic [3:0] meas_key;
  logic [15:0] key_detect;
  logic [7:0] slider_pos;
  logic slider_touch;
  logic [15:0] touch = 16'h0000;
  logic [7:0] depth = 8'h0A;
  logic [15:0][9:0] key_pulses;
  int failures = 0;
  int compares = 0;
  logic [7:0] rv;
  int q;
  logic [7:0] ra [11] = '{8'h13, 8'h14, 8'h15, 8'h16, 8'h25, 8'h26, 8'h35, 8'h36, 8'h45, 8'h46, 8'h47};
  logic [7:0] re [11] = '{8'h19, 8'h05, 8'h04, 8'h00, 8'h00, 8'h0A, 8'h0A, 8'h04, 8'h04, 8'h00, 8'h00};
  logic [7:0] ma [5] = '{8'h15, 8'h16, 8'h47, 8'h50, 8'h26};
  logic [7:0] me [5] = '{8'h07, 8'h03, 8'h1C, 8'h00, 8'h0C};

  always #50 clk_sys = ~clk_sys;

  tsr_core #(.TICK_CYC(20), .LP_CYC(8)) uut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sleep_interval_setting(sleep_interval_setting), .ded_dir(ded_dir), .pwm_shared_en(pwm_shared_en),
    .pwm_ded_en(pwm_ded_en), .pwm_level(pwm_level), .key_signal(key_signal), .slider_raw_pos(slider_raw_pos),
    .drive_line(drive_line), .recv_en(recv_en), .ded_out(ded_out), .ded_oe(ded_oe), .meas_key(meas_key),
    .key_detect(key_detect), .slider_pos(slider_pos), .slider_touch(slider_touch));

  tsr_matrix_model matrix (.clk_sys(clk_sys), .rst_b(rst_b), .meas_key(meas_key), .drive_line(drive_line),
    .recv_en(recv_en), .touch(touch), .depth(depth), .key_signal(key_signal), .key_pulses(key_pulses));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  // two passes so that at least one whole scan follows any change
  task automatic scan();
    int n;
    repeat (2) begin
      n = 0;
      while (meas_key !== 4'hF && n < 5000) begin
        @(posedge clk_sys);
        n++;
      end
      while (meas_key === 4'hF && n < 5000) begin
        @(posedge clk_sys);
        n++;
      end
      if (n >= 5000) begin
        failures++;
        finish_test();
      end
    end
  endtask : scan

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      rd(ra[i], rv);
      chk("reset value", 16'(rv), 16'(re[i]));
    end
    for (int i = 0; i < 5; i++) begin
      wr(ma[i], 8'hFF - ((i == 4) ? 8'hF3 : 8'h00));
      rd(ma[i], rv);
      chk("write back", 16'(rv), 16'(me[i]));
    end
    wr(8'h15, 8'h04);
    wr(8'h26, 8'h0A);
    for (int k = 0; k < 16; k++) begin
      wr(8'h36 + 8'(k), (k == 12) ? 8'h00 : ((k == 5) ? 8'h02 : 8'h01));
      wr(8'h16 + 8'(k), (k == 9 || k == 10) ? 8'h01 : ((k < 2) ? 8'h02 : 8'h00));
    end
    scan();
    chk("pulses key0", 16'(key_pulses[0]), 16'h0004);
    chk("pulses key5", 16'(key_pulses[5]), 16'h0008);
    touch <= 16'h1603;
    scan();
    chk("detect at threshold", 16'(key_detect[9]), 16'h0001);
    chk("same group blocked", 16'(key_detect[10]), 16'h0000);
    chk("disabled key", 16'(key_detect[12]), 16'h0000);
    chk("slider keys both", 16'(key_detect[1:0]), 16'h0003);
    chk("slider touch", 16'(slider_touch), 16'h0001);
    chk("slider pos", 16'(slider_pos), 16'h000B);
    wr(8'h15, 8'h00);
    wr(8'h14, 8'h35);
    slider_raw_pos <= 8'hB9;
    scan();
    chk("first scroll held", 16'(slider_pos), 16'h00B7);
    slider_raw_pos <= 8'hBB;
    scan();
    chk("first scroll moved", 16'(slider_pos), 16'h00BB);
    slider_raw_pos <= 8'hB9;
    scan();
    chk("reverse held", 16'(slider_pos), 16'h00BB);
    depth <= 8'h09;
    scan();
    chk("hold inside band", 16'(key_detect[9]), 16'h0001);
    depth <= 8'h07;
    scan();
    chk("release", 16'(key_detect[9]), 16'h0000);
    touch <= 16'h0400;
    depth <= 8'h0A;
    scan();
    chk("no drift while held", 16'(key_detect[10]), 16'h0001);
    touch <= 16'h0000;
    scan();
    wr(8'h46, 8'hA5);
    wr(8'h13, 8'h0D);
    wr(8'h47, 8'h1C);
    ded_dir <= 3'h7;
    sleep_interval_setting <= 8'h00;
    q = 0;
    for (int n = 0; n < 5000 && q < 300; n++) begin
      @(posedge clk_sys);
      q = (recv_en === 2'b00) ? q + 1 : 0;
    end
    chk("scans stop", 16'(q), 16'h012C);
    chk("shared level", 16'(drive_line), 16'h00A5);
    chk("ded level", 16'(ded_out), 16'h0007);
    chk("ded enable", 16'(ded_oe), 16'h0007);
    ded_dir <= 3'h2;
    pwm_shared_en <= 8'h0F;
    pwm_ded_en <= 3'h2;
    repeat (3) @(posedge clk_sys);
    chk("pwm shared low", 16'(drive_line), 16'h00A0);
    chk("pwm ded low", 16'({ded_oe, ded_out}), 16'h0010);
    pwm_level <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("pwm shared high", 16'(drive_line), 16'h00AF);
    chk("pwm ded high", 16'({ded_oe, ded_out}), 16'h0012);
    finish_test();
  end
endmodule : tb_top
